// file: logic/lfsup_pkg.sv
// Purpose: Constants for the LED fault supervisor.
// Assumes: Analog comparisons arrive as logic flags; the delay capacitor is a counter.
// Notes: Counter codes scale 1 LSB to 1 mV of delay-node voltage.
package lfsup_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned BLANK_NS     = 1600;
  localparam int unsigned BLANK_CYC    = (BLANK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned DLY_W        = 12;
  localparam logic [11:0] DLY_MAX      = 12'he10;  // 3600 mV
  localparam logic [11:0] DLY_TRIP     = 12'haf0;  // 2800 mV
  localparam logic [11:0] DLY_RESTART  = 12'h15e;  // 350 mV
  localparam logic [11:0] CHARGE_STEP  = 12'h001;
  localparam logic [11:0] DISCH_STEP   = 12'h001;
  // Source 57 uA versus sink 1.8 uA: discharge steps once per this many ticks.
  localparam int unsigned DISCH_DIV    = 32;
  typedef enum logic [1:0] {LFSUP_STANDBY, LFSUP_SOFTSTART, LFSUP_RUN, LFSUP_SHUTDOWN} lfsup_state_t;
endpackage : lfsup_pkg

// file: logic/lfsup_top.sv
// Purpose: Fault classing, delay timer and restart control for an LED driver.
// Assumes: Comparator and status flags are asynchronous to core_clk.
// Notes: Timer charges once per rate_tick and discharges once per 32 ticks so real delays can be scaled.
`timescale 1ns/1ps
module lfsup_top
  import lfsup_pkg::*;
#(
  parameter int unsigned SOFTSTART_CYC = 64
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Timing
  input  wire logic rate_tick,
  // Sense flags
  input  wire logic short_detect_low,
  input  wire logic short_detect_high,
  input  wire logic anode_overvoltage,
  input  wire logic anode_undervoltage,
  input  wire logic cathode_feedback_low,
  input  wire logic led_on,
  input  wire logic delay_node_grounded,
  input  wire logic auxiliary_string_off_grounded,
  // Class-3 conditions
  input  wire logic supply_undervoltage_lockout,
  input  wire logic enable_low,
  input  wire logic die_overtemp_shutdown,
  input  wire logic led_thermistor_input,
  // Status
  output logic [lfsup_pkg::DLY_W-1:0] delay_capacitor,
  output logic                        regulate,
  output logic                        soft_start,
  output logic                        fault_shutdown,
  output logic                        auto_restart,
  output logic                        class1_fault,
  output logic                        class2_fault
);
  import lfsup_pkg::*;

  localparam int NS = 9;
  logic [NS-1:0] raw, s1, s2, s3, filt;
  assign raw = {short_detect_low, short_detect_high, anode_overvoltage, anode_undervoltage,
                cathode_feedback_low, delay_node_grounded, auxiliary_string_off_grounded,
                led_on, supply_undervoltage_lockout | enable_low | die_overtemp_shutdown | led_thermistor_input};

  // Three-stage sync; a change counts only once stages two and three agree.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else if (clk_en) begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < NS; i++) begin
        if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
      end
    end
  end

  logic f_short_lo, f_short_hi, f_ov, f_uv, f_cath_low, f_gnd, f_aux, f_on, f_c3;
  assign {f_short_lo, f_short_hi, f_ov, f_uv, f_cath_low, f_gnd, f_aux, f_on, f_c3} = filt;

  lfsup_state_t state;
  logic [15:0] ss_cnt;
  logic [$clog2(BLANK_CYC+1)-1:0] blank_cnt;
  logic on_q, blank_done, cath_latch;
  logic [4:0] dis_div;

  // Blanking after each turn-on hides string-side comparators.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      on_q <= 1'b0;
      blank_cnt <= '0;
    end else if (clk_en) begin
      on_q <= f_on;
      if (f_on && !on_q) begin
        blank_cnt <= '0;
      end else if (f_on && !blank_done) begin
        blank_cnt <= blank_cnt + 1'b1;
      end
    end
  end
  assign blank_done = (32'(blank_cnt) >= BLANK_CYC) && f_on && on_q;

  logic det_ok, c1, ov_uv, c2_string, c2_any, on_gate;
  assign det_ok    = (state == LFSUP_RUN) && blank_done;
  assign c1        = det_ok && f_short_lo && !f_short_hi;
  assign c2_string = det_ok && f_short_hi;
  assign ov_uv     = (state == LFSUP_RUN) && (f_ov || f_uv);
  assign c2_any    = c2_string || ov_uv || cath_latch;
  assign on_gate   = f_on || ov_uv || cath_latch;
  assign class1_fault = c1;
  assign class2_fault = c2_any;

  // Cathode short latched at end of soft-start until shutdown.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cath_latch <= 1'b0;
    end else if (clk_en) begin
      if (state != LFSUP_RUN) begin
        cath_latch <= (state == LFSUP_SOFTSTART) && ss_cnt == 16'(SOFTSTART_CYC - 1) && f_cath_low;
      end
    end
  end

  // The strap is caught on the last soft-start cycle, once the synchroniser has settled after reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_restart <= 1'b0;
    end else if (clk_en && state == LFSUP_SOFTSTART && ss_cnt == 16'(SOFTSTART_CYC - 1)) begin
      auto_restart <= f_aux;
    end
  end

  // State machine; class-3 overrides everything.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= LFSUP_STANDBY;
      ss_cnt <= '0;
    end else if (clk_en) begin
      if (f_c3) begin
        state <= LFSUP_STANDBY;
        ss_cnt <= '0;
      end else begin
        unique case (state)
          LFSUP_STANDBY: begin
            state <= LFSUP_SOFTSTART;
            ss_cnt <= '0;
          end
          LFSUP_SOFTSTART: begin
            if (ss_cnt == 16'(SOFTSTART_CYC - 1)) begin
              state <= LFSUP_RUN;
            end else begin
              ss_cnt <= ss_cnt + 1'b1;
            end
          end
          LFSUP_RUN: begin
            if (c2_any && !f_gnd && delay_capacitor >= DLY_TRIP) begin
              state <= LFSUP_SHUTDOWN;
            end
          end
          LFSUP_SHUTDOWN: begin
            // Without auto-restart only a class-3 condition (enable, UVLO, overtemp, thermistor) or reset leaves here.
            if (auto_restart && delay_capacitor <= DLY_RESTART) begin
              state <= LFSUP_SOFTSTART;
              ss_cnt <= '0;
            end
          end
        endcase
      end
    end
  end

  // Delay capacitor model.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      delay_capacitor <= '0;
      dis_div <= '0;
    end else if (clk_en && rate_tick) begin
      dis_div <= dis_div + 1'b1;
      if (f_gnd) begin
        delay_capacitor <= '0;
      end else if (state == LFSUP_STANDBY || state == LFSUP_SOFTSTART) begin
        delay_capacitor <= delay_capacitor;
      end else if (state == LFSUP_SHUTDOWN) begin
        if (!auto_restart) begin
          delay_capacitor <= (delay_capacitor + CHARGE_STEP > DLY_MAX) ? DLY_MAX
                           : delay_capacitor + CHARGE_STEP;
        end else if (f_ov) begin
          delay_capacitor <= delay_capacitor;
        end else if (dis_div == '0 && delay_capacitor > DLY_RESTART) begin
          delay_capacitor <= delay_capacitor - DISCH_STEP;
        end
      end else if (!on_gate) begin
        delay_capacitor <= delay_capacitor;
      end else if (c2_any && delay_capacitor >= DLY_TRIP) begin
        // Shutdown takes effect on this edge, so the node stops at the level that tripped it.
        delay_capacitor <= delay_capacitor;
      end else if (c1 || c2_any) begin
        delay_capacitor <= (delay_capacitor + CHARGE_STEP > DLY_MAX) ? DLY_MAX
                         : delay_capacitor + CHARGE_STEP;
      end else if (dis_div == '0 && delay_capacitor != '0 && blank_done) begin
        delay_capacitor <= delay_capacitor - DISCH_STEP;
      end
    end
  end

  assign regulate       = (state == LFSUP_RUN);
  assign soft_start     = (state == LFSUP_SOFTSTART);
  assign fault_shutdown = (state == LFSUP_SHUTDOWN);

  chk_c3_standby: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && f_c3 |=> state == LFSUP_STANDBY) else $error("class-3 did not force standby");
  chk_c1_no_shut: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && state == LFSUP_RUN && !c2_any |=> state != LFSUP_SHUTDOWN)
    else $error("shutdown without class-2");
  chk_dly_cap: assert property (@(posedge core_clk) disable iff (rst)
    delay_capacitor <= DLY_MAX) else $error("timer above limit");
  chk_gnd_noshut: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && f_gnd && state == LFSUP_RUN |=> state != LFSUP_SHUTDOWN)
    else $error("shutdown with grounded node");
  chk_off_hold: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && state == LFSUP_RUN && !on_gate && !f_gnd |=> $stable(delay_capacitor))
    else $error("timer moved while off");
  chk_c2_trip: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && state == LFSUP_RUN && c2_any && !f_gnd && !f_c3 && delay_capacitor >= DLY_TRIP
    |=> state == LFSUP_SHUTDOWN) else $error("missed class-2 shutdown");
  chk_ov_hold: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && fault_shutdown && auto_restart && f_ov && !f_gnd && !f_c3 |=> $stable(delay_capacitor))
    else $error("timer moved during overvoltage");
  chk_restart: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && fault_shutdown && auto_restart && !f_c3 && delay_capacitor <= DLY_RESTART
    |=> state == LFSUP_SOFTSTART) else $error("no auto restart");
  chk_blank: assert property (@(posedge core_clk) disable iff (rst)
    f_on && !on_q |-> !c1 && !c2_string) else $error("fault seen during blanking");

  // Multi-step behaviours are spelt out as sequences so the properties read as cause and effect.
  sequence seq_trip_tick;
    clk_en && rate_tick && state == LFSUP_RUN && c2_any && !f_gnd && !f_c3 && delay_capacitor >= DLY_TRIP;
  endsequence
  sequence seq_held_in_shutdown;
    fault_shutdown && $stable(delay_capacitor);
  endsequence
  sequence seq_softstart_end;
    clk_en && !f_c3 && state == LFSUP_SOFTSTART && ss_cnt == 16'(SOFTSTART_CYC - 1);
  endsequence
  sequence seq_run_with_strap;
    regulate && auto_restart == $past(f_aux);
  endsequence

  chk_trip_hold: assert property (@(posedge core_clk) disable iff (rst)
    seq_trip_tick |=> seq_held_in_shutdown) else $error("timer passed the trip level");
  chk_strap_take: assert property (@(posedge core_clk) disable iff (rst)
    seq_softstart_end |=> seq_run_with_strap) else $error("strap not taken at soft-start end");
  chk_shut_charge: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && fault_shutdown && !auto_restart && !f_gnd && delay_capacitor < DLY_MAX
    |=> delay_capacitor == $past(delay_capacitor) + CHARGE_STEP) else $error("timer idle after shutdown");
  chk_gnd_zero: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && f_gnd |=> delay_capacitor == '0) else $error("grounded node not at zero");
  chk_standby_hold: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && !f_gnd && (state == LFSUP_STANDBY || state == LFSUP_SOFTSTART)
    |=> $stable(delay_capacitor)) else $error("timer moved in standby");
  chk_auto_fall: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && fault_shutdown && auto_restart && !f_gnd
    |=> delay_capacitor <= $past(delay_capacitor)) else $error("timer rose during restart wait");
  chk_restart_wait: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && fault_shutdown && auto_restart && !f_c3 && delay_capacitor > DLY_RESTART
    |=> fault_shutdown) else $error("restart before timer fell");
  chk_anode_charge: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && state == LFSUP_RUN && f_uv && !f_on && !f_gnd && delay_capacitor < DLY_TRIP
    |=> delay_capacitor == $past(delay_capacitor) + CHARGE_STEP) else $error("anode fault gated by dimming");
  chk_c1_charge: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && state == LFSUP_RUN && c1 && !c2_any && !f_gnd && delay_capacitor < DLY_MAX
    |=> delay_capacitor == $past(delay_capacitor) + CHARGE_STEP) else $error("class-1 did not charge");
  chk_c1_sat: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rate_tick && state == LFSUP_RUN && c1 && !c2_any && !f_gnd && delay_capacitor == DLY_MAX
    |=> delay_capacitor == DLY_MAX) else $error("class-1 timer left its ceiling");
  chk_cath_keep: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && state == LFSUP_RUN && cath_latch && !f_c3
    |=> class2_fault || fault_shutdown) else $error("cathode fault dropped before shutdown");
endmodule : lfsup_top

// file: verif/lfsup_led_model.sv
// Purpose: LED strings, boost output and sense comparators beside the supervisor.
// Assumes: The bench selects one fault kind at a time and changes it off the sampling edge.
// Notes: Codes 1 to 5 each raise one fault; code 0 leaves every comparator quiet.
`timescale 1ns/1ps
module lfsup_led_model (
  // Control from the bench
  input  wire logic [2:0] fault_sel,
  input  wire logic       dim_on,
  // Comparator flags
  output logic            short_detect_low,
  output logic            short_detect_high,
  output logic            anode_overvoltage,
  output logic            anode_undervoltage,
  output logic            cathode_feedback_low,
  output logic            led_on
);
  // A whole-string short lifts the sense node past both comparators.
  assign short_detect_low     = (fault_sel == 3'h1) || (fault_sel == 3'h2);
  assign short_detect_high    = (fault_sel == 3'h2);
  assign anode_overvoltage    = (fault_sel == 3'h3);
  assign anode_undervoltage   = (fault_sel == 3'h4);
  assign cathode_feedback_low = (fault_sel == 3'h5);
  assign led_on               = dim_on;
endmodule : lfsup_led_model

// file: verif/lfsup_top_tb.sv
// Purpose: Self-checking bench for the LED fault supervisor.
// Assumes: The rate tick is held high, so the timer charges every clock and discharges every 32nd clock.
// Notes: The slow discharge makes the auto-restart case most of the run.
`timescale 1ns/1ps
module lfsup_top_tb;
  import lfsup_pkg::*;
  logic        core_clk = 0, rst = 1, dim_on = 0, ground_node = 0, strap = 0, en_low = 0, hot = 0, run_en = 1;
  logic [2:0]  fault_sel = 3'h0;
  logic [11:0] dly, v;
  logic        regulate, soft_start, fault_shutdown, auto_restart, class1, class2;
  logic        sdl, sdh, aov, auv, cfl, led;
  int          num_errors = 0, total_checks = 0;
  always #25 core_clk = ~core_clk;
  lfsup_led_model lfsup_led_model_inst (.fault_sel(fault_sel), .dim_on(dim_on), .short_detect_low(sdl),
    .short_detect_high(sdh), .anode_overvoltage(aov), .anode_undervoltage(auv), .cathode_feedback_low(cfl),
    .led_on(led));
  lfsup_top #(.SOFTSTART_CYC(8)) lfsup_top_inst (.core_clk(core_clk), .rst(rst), .clk_en(run_en),
    .rate_tick(1'b1), .short_detect_low(sdl), .short_detect_high(sdh), .anode_overvoltage(aov),
    .anode_undervoltage(auv), .cathode_feedback_low(cfl), .led_on(led), .delay_node_grounded(ground_node),
    .auxiliary_string_off_grounded(strap), .supply_undervoltage_lockout(1'b0), .enable_low(en_low),
    .die_overtemp_shutdown(1'b0), .led_thermistor_input(hot), .delay_capacitor(dly), .regulate(regulate),
    .soft_start(soft_start), .fault_shutdown(fault_shutdown), .auto_restart(auto_restart),
    .class1_fault(class1), .class2_fault(class2));
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({11'h000, got}, {11'h000, exp});
  endtask : chk_bit
  // Bounded wait: 0 soft-start, 1 regulate, 2 shutdown, 3 timer at its ceiling.
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    while (!(which == 0 ? soft_start === 1'b1 : which == 1 ? regulate === 1'b1 :
             which == 2 ? fault_shutdown === 1'b1 : dly === DLY_MAX)) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("[FAIL] %0t wait %h timed out", $time, which);
        close_out();
      end
    end
  endtask : wait_for
  task automatic do_reset(input logic s);
    @(negedge core_clk);
    rst = 1;
    fault_sel = 3'h0;
    strap = s;
    repeat (16) @(negedge core_clk);
    chk_val(dly, 12'h000);
    rst = 0;
    wait_for(0, 40);
    wait_for(1, 100);
  endtask : do_reset
  task automatic s_class1;
    do_reset(1'b0);
    fault_sel = 3'h1;
    dim_on = 1;
    repeat (25) @(negedge core_clk);
    chk_bit(class1, 1'b0);
    chk_val(dly, 12'h000);
    repeat (60) @(negedge core_clk);
    chk_bit(class1, 1'b1);
    chk_bit(dly > 12'h000, 1'b1);
    run_en = 0;
    v = dly;
    repeat (20) @(negedge core_clk);
    chk_val(dly, v);
    run_en = 1;
    dim_on = 0;
    repeat (10) @(negedge core_clk);
    v = dly;
    repeat (50) @(negedge core_clk);
    chk_val(dly, v);
    dim_on = 1;
    wait_for(3, 4000);
    chk_bit(fault_shutdown, 1'b0);
    chk_bit(regulate, 1'b1);
    hot = 1;
    repeat (10) @(negedge core_clk);
    chk_bit(regulate, 1'b0);
    hot = 0;
    wait_for(0, 60);
  endtask : s_class1
  task automatic s_class2;
    do_reset(1'b0);
    fault_sel = 3'h2;
    repeat (100) @(negedge core_clk);
    chk_bit(class2, 1'b1);
    wait_for(2, 4000);
    chk_bit(dly >= DLY_TRIP && dly < DLY_TRIP + 12'h010, 1'b1);
    wait_for(3, 1000);
    fault_sel = 3'h0;
    repeat (100) @(negedge core_clk);
    chk_bit(fault_shutdown, 1'b1);
    en_low = 1;
    repeat (20) @(negedge core_clk);
    en_low = 0;
    wait_for(0, 60);
    chk_bit(soft_start, 1'b1);
  endtask : s_class2
  task automatic s_ground;
    do_reset(1'b0);
    ground_node = 1;
    fault_sel = 3'h4;
    dim_on = 0;
    repeat (3000) @(negedge core_clk);
    chk_bit(class2, 1'b1);
    chk_bit(fault_shutdown, 1'b0);
    chk_val(dly, 12'h000);
    ground_node = 0;
    repeat (100) @(negedge core_clk);
    chk_bit(dly > 12'h000, 1'b1);
    v = dly;
    fault_sel = 3'h0;
    dim_on = 1;
    repeat (400) @(negedge core_clk);
    chk_bit(dly < v && dly > v - 12'h020, 1'b1);
  endtask : s_ground
  task automatic s_cathode;
    do_reset(1'b0);
    en_low = 1;
    repeat (10) @(negedge core_clk);
    fault_sel = 3'h5;
    en_low = 0;
    wait_for(1, 100);
    fault_sel = 3'h0;
    repeat (50) @(negedge core_clk);
    chk_bit(class2, 1'b1);
    wait_for(2, 4000);
    chk_bit(dly >= DLY_TRIP, 1'b1);
  endtask : s_cathode
  task automatic s_auto;
    do_reset(1'b1);
    chk_bit(auto_restart, 1'b1);
    fault_sel = 3'h3;
    repeat (100) @(negedge core_clk);
    chk_bit(class2, 1'b1);
    wait_for(2, 4000);
    repeat (200) @(negedge core_clk);
    chk_val(dly, DLY_TRIP);
    fault_sel = 3'h0;
    wait_for(0, 82000);
    chk_bit(dly <= DLY_RESTART, 1'b1);
  endtask : s_auto
  initial begin
    s_class1();
    s_class2();
    s_ground();
    s_cathode();
    s_auto();
    close_out();
  end
endmodule : lfsup_top_tb
